// [dv/tb_top.sv]
// self-checking bench of the timer/counter with shared prescaler
`timescale 1ns/100ps
module tb_top;
	import tcp_pkg::*;
	logic mclk, rst, reg_wr, reg_rd, sleep, watchdog_clear_instr, wdt_tick;
	logic count_input_pin, timer_irq, wdt_timeout;
	logic [ADDR_W-1:0] reg_addr;
	logic [DATA_W-1:0] reg_wdata, reg_rdata, rv;
	int err_count = 0;
	int checks_done = 0;
	int wdt_seen = 0;
	int base, k, mdl_count, mdl_opt;

	tcp_top u_tcp_top (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.count_input_pin(count_input_pin), .sleep(sleep),
		.watchdog_clear_instr(watchdog_clear_instr), .wdt_tick(wdt_tick),
		.timer_irq(timer_irq), .wdt_timeout(wdt_timeout));
	tcp_cnt_src u_tcp_cnt_src (.mclk(mclk), .pin(count_input_pin));

	// =====================================================================
	// clock, time limit, watchdog
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end

	initial begin
		#100000;
		err_count++;
		results();
	end

	always @(posedge mclk) begin
		if (rst === 1'b0 && wdt_timeout === 1'b1) begin
			wdt_seen++;
		end
	end

	// =====================================================================
	// compare and report
	task automatic check_rd(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t read %h expected %h", $time, got, exp);
		end
	endtask

	task automatic check_bit(input logic got, input logic exp);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t irq %b expected %b", $time, got, exp);
		end
	endtask

	task automatic check_cnt(input int got, input int exp);
		checks_done++;
		if (got != exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t pulses %0d expected %0d", $time, got, exp);
		end
	endtask

	task automatic results();
		$display("mismatches %0d comparisons %0d", err_count, checks_done);
		if (err_count == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// =====================================================================
	// register bus and stimulus
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
		@(posedge mclk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	task automatic set_opt(input int v);
		mdl_opt = v;
		wr(ADDR_OPTION, DATA_W'(v));
		rd(ADDR_OPTION, rv);
		check_rd(rv, DATA_W'(mdl_opt));
	endtask

	// reads taken exactly cyc edges apart must differ by k
	task automatic span_check(input int cyc, input int k);
		logic [DATA_W-1:0] a, b;
		rd(ADDR_COUNT, a);
		repeat (cyc - 2) @(posedge mclk);
		rd(ADDR_COUNT, b);
		check_rd(b, a + DATA_W'(k));
	endtask

	task automatic irq_after(input logic exp);
		repeat (3) @(posedge mclk);
		#1 check_bit(timer_irq, exp);
	endtask

	task automatic tick();
		@(posedge mclk);
		wdt_tick <= 1'b1;
		repeat (4) @(posedge mclk);
		wdt_tick <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	task automatic wclr();
		@(posedge mclk);
		watchdog_clear_instr <= 1'b1;
		@(posedge mclk);
		watchdog_clear_instr <= 1'b0;
	endtask

	// =====================================================================
	// main sequence
	initial begin
		rst = 1'b1;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = '0;
		reg_wdata = '0;
		sleep = 1'b0;
		watchdog_clear_instr = 1'b0;
		wdt_tick = 1'b0;
		void'($urandom(32'hc17c));
		repeat (6) @(posedge mclk);
		rst <= 1'b0;
		rd(ADDR_OPTION, rv);
		check_rd(rv, OPTION_RST);
		rd(ADDR_IRQ_CTRL, rv);
		check_rd(rv, 8'h00);
		rd(ADDR_COUNT, rv);
		check_rd(rv, COUNT_RST);
		rd(8'h55, rv);
		check_rd(rv, 8'h00);
		set_opt(8'h08);
		k = 3 + $urandom % 10;
		span_check(4 * k, k);
		mdl_count = $urandom % 200;
		wr(ADDR_COUNT, DATA_W'(mdl_count));
		repeat (4) @(posedge mclk);
		rd(ADDR_COUNT, rv);
		check_rd(rv, DATA_W'(mdl_count));
		for (int n = 0; n < 8; n++) begin
			set_opt(n);
			span_check(16 << n, 2);
		end
		set_opt(8'h08);
		@(posedge mclk);
		sleep <= 1'b1;
		repeat (4) @(posedge mclk);
		span_check(64, 0);
		@(posedge mclk);
		sleep <= 1'b0;
		// overflow with the request masked, then enabled, then flag cleared
		wr(ADDR_IRQ_CTRL, 8'h00);
		wr(ADDR_COUNT, 8'hff);
		repeat (20) @(posedge mclk);
		#1 check_bit(timer_irq, 1'b0);
		rd(ADDR_IRQ_CTRL, rv);
		check_rd(rv, 8'h04);
		repeat (40) @(posedge mclk);
		rd(ADDR_IRQ_CTRL, rv);
		check_rd(rv, 8'h04);
		wr(ADDR_IRQ_CTRL, 8'h24);
		irq_after(1'b1);
		wr(ADDR_IRQ_CTRL, 8'h20);
		irq_after(1'b0);
		// pin edges with prescaler bypassed, both edge choices
		for (int e = 0; e < 2; e++) begin
			u_tcp_cnt_src.set_idle(e[0]);
			set_opt(e ? 8'h38 : 8'h28);
			mdl_count = $urandom % 200;
			wr(ADDR_COUNT, DATA_W'(mdl_count));
			repeat (20) @(posedge mclk);
			k = 1 + $urandom % 5;
			u_tcp_cnt_src.pulses(k);
			u_tcp_cnt_src.level(!e[0]);
			repeat (20) @(posedge mclk);
			rd(ADDR_COUNT, rv);
			check_rd(rv, DATA_W'(mdl_count + k + 1));
			u_tcp_cnt_src.level(e[0]);
			repeat (20) @(posedge mclk);
			rd(ADDR_COUNT, rv);
			check_rd(rv, DATA_W'(mdl_count + k + 1));
		end
		// divide by 8: a count write must restart the prescaler
		u_tcp_cnt_src.set_idle(1'b0);
		set_opt(8'h22);
		u_tcp_cnt_src.pulses(5);
		wr(ADDR_COUNT, 8'h10);
		repeat (20) @(posedge mclk);
		u_tcp_cnt_src.pulses(4);
		repeat (20) @(posedge mclk);
		rd(ADDR_COUNT, rv);
		check_rd(rv, 8'h11);
		u_tcp_cnt_src.pulses(8);
		repeat (20) @(posedge mclk);
		rd(ADDR_COUNT, rv);
		check_rd(rv, 8'h12);
		// watchdog side: clear restarts the shared prescaler
		set_opt(8'h0a);
		wclr();
		repeat (4) @(posedge mclk);
		base = wdt_seen;
		tick();
		wclr();
		tick();
		repeat (4) @(posedge mclk);
		check_cnt(wdt_seen, base);
		tick();
		repeat (4) @(posedge mclk);
		check_cnt(wdt_seen, base + 1);
		set_opt(8'h02);
		base = wdt_seen;
		repeat (8) tick();
		check_cnt(wdt_seen, base);
		wr(8'h55, 8'hff);
		rd(ADDR_OPTION, rv);
		check_rd(rv, DATA_W'(mdl_opt));
		results();
	end
endmodule

// [dv/tcp_cnt_src.sv]
// external count source that drives the counter's input pin
`timescale 1ns/100ps
module tcp_cnt_src (
	input wire logic mclk,
	output logic pin
);
	// =====================================================================
	// pulse generator
	// 8 mclk per level keeps it over four phase samples, scaled or not
	localparam int HALF_CYC = 8;
	logic idle_lvl = 1'b1;

	initial begin
		pin = 1'b1;
	end

	task automatic level(input logic lvl);
		@(posedge mclk);
		pin <= lvl;
	endtask

	task automatic set_idle(input logic lvl);
		idle_lvl = lvl;
		level(lvl);
	endtask

	// each pulse leaves idle and comes back, so one edge of each kind
	task automatic pulses(input int n);
		for (int i = 0; i < n; i++) begin
			level(!idle_lvl);
			repeat (HALF_CYC - 1) @(posedge mclk);
			level(idle_lvl);
			repeat (HALF_CYC - 1) @(posedge mclk);
		end
	endtask
endmodule

// [logic/tcp_pkg.sv]
// shared constants and types of the timer/counter with shared prescaler
package tcp_pkg;

	// =====================================================================
	// register map
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'h01;
	localparam logic [ADDR_W-1:0] ADDR_IRQ_CTRL = 8'h0b;
	localparam logic [ADDR_W-1:0] ADDR_OPTION = 8'h81;

	// =====================================================================
	// field positions
	localparam int OPT_CS_BIT = 5;
	localparam int OPT_EDGE_BIT = 4;
	localparam int OPT_PSA_BIT = 3;
	localparam int OPT_RATIO_LSB = 0;
	localparam int RATIO_W = 3;
	localparam int IRQ_EN_BIT = 5;
	localparam int IRQ_FLAG_BIT = 2;

	// =====================================================================
	// reset values
	localparam logic [DATA_W-1:0] OPTION_RST = 8'hff;
	localparam logic [DATA_W-1:0] COUNT_RST = 8'h00;
	localparam logic [DATA_W-1:0] COUNT_MAX = 8'hff;

	// =====================================================================
	// timing
	localparam int CLK_PERIOD_NS = 4;
	localparam int Q_PER_INSTR = 4;
	localparam int INSTR_TIME_NS = Q_PER_INSTR * CLK_PERIOD_NS;
	localparam int INHIBIT_INSTR = 2;
	localparam int INHIBIT_CYC = INHIBIT_INSTR * INSTR_TIME_NS / CLK_PERIOD_NS;
	localparam int INH_W = 4;
	localparam int PSC_W = 8;

	typedef enum logic [3:0] {
		TCP_Q1 = 4'h1,
		TCP_Q2 = 4'h2,
		TCP_Q3 = 4'h4,
		TCP_Q4 = 4'h8
	} tcp_phase_e;

endpackage

// [logic/tcp_presc_if.sv]
// link between the timer core and the shared prescaler
`timescale 1ns/100ps
interface tcp_presc_if;
	import tcp_pkg::*;
	logic clr;
	logic run;
	logic in_level;
	logic [RATIO_W-1:0] ratio;
	logic out_tmr;
	logic out_wdt;
	logic [PSC_W-1:0] cnt;
	modport ctl (output clr, output run, output in_level, output ratio,
		input out_tmr, input out_wdt, input cnt);
	modport psc (input clr, input run, input in_level, input ratio,
		output out_tmr, output out_wdt, output cnt);
endinterface

// [logic/tcp_prescaler.sv]
// shared 8-bit prescaler, counts rising edges of its input level
`timescale 1ns/100ps
module tcp_prescaler #(
	parameter int W = tcp_pkg::PSC_W
) (
	input wire logic mclk,
	input wire logic rst,
	tcp_presc_if.psc pif
);
	import tcp_pkg::*;

	logic in_prev_ff;
	logic [W-1:0] cnt_ff;

	function automatic logic sel_bit(input logic [W-1:0] v, input int idx);
		return v[idx];
	endfunction

	// =====================================================================
	// edge counter
	always_ff @(posedge mclk) begin
		if (rst) begin
			in_prev_ff <= 1'h0;
		end else begin
			in_prev_ff <= pif.in_level;
		end
	end

	// a tap of a binary counter is a square wave: same result as a ripple chain
	always_ff @(posedge mclk) begin
		if (rst || pif.clr) begin
			cnt_ff <= '0;
		end else if (pif.run && pif.in_level && !in_prev_ff) begin
			cnt_ff <= cnt_ff + 1'h1;
		end
	end

	assign pif.cnt = cnt_ff;
	assign pif.out_tmr = sel_bit(cnt_ff, int'(pif.ratio));
	assign pif.out_wdt = (pif.ratio == '0) ? pif.in_level : sel_bit(cnt_ff, int'(pif.ratio) - 1);

	// =====================================================================
	// checks
	property p_psc_clear;
		@(posedge mclk) disable iff (rst) pif.clr |=> (cnt_ff == '0);
	endproperty
	a_psc_clear: assert property (p_psc_clear) else $error("prescaler not cleared");

	property p_psc_step;
		@(posedge mclk) disable iff (rst)
		(pif.run && pif.in_level && !in_prev_ff && !pif.clr) |=> (cnt_ff == $past(cnt_ff) + 1'h1);
	endproperty
	a_psc_step: assert property (p_psc_step) else $error("prescaler missed an edge");

endmodule

// [logic/tcp_q_sampler.sv]
// samples a level only in the second and fourth phase of each cycle
`timescale 1ns/100ps
module tcp_q_sampler (
	input wire logic mclk,
	input wire logic rst,
	input wire logic level,
	input wire logic sample_en,
	output logic rise
);
	logic samp_ff;
	logic prev_ff;

	always_ff @(posedge mclk) begin
		if (rst) begin
			samp_ff <= 1'h0;
		end else if (sample_en) begin
			samp_ff <= level;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			prev_ff <= 1'h0;
		end else begin
			prev_ff <= samp_ff;
		end
	end

	assign rise = samp_ff && !prev_ff;

	property p_sample_phase;
		@(posedge mclk) disable iff (rst) $changed(samp_ff) |-> $past(sample_en);
	endproperty
	a_sample_phase: assert property (p_sample_phase) else $error("sample outside phase");

endmodule

// [logic/tcp_top.sv]
// 8-bit timer/counter with prescaler shared with the watchdog
// How it works
// - timer mode counts every instruction cycle
// - write to count stalls two cycles
// - counter mode counts chosen pin edge
// - one prescaler, assignment bit picks owner
// - ratio field and assignment set division
// - wrap from max to zero sets flag
// - enable bit gates the interrupt request
// - no counting while asleep
// - timer bypasses prescaler when it is assigned to the watchdog; watchdog gives no timeout when it is not
// - sample path at phases two and four
// - extra delay after synchronising edge
// - prescaler divides into a symmetric output
// - 8-bit prescaler serves only one owner
// - count write clears prescaler when assigned
// - watchdog clear clears prescaler when assigned
`timescale 1ns/100ps
module tcp_top (
	input wire logic mclk,
	input wire logic rst,
	input wire logic [tcp_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [tcp_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [tcp_pkg::DATA_W-1:0] reg_rdata,
	input wire logic count_input_pin,
	input wire logic sleep,
	input wire logic watchdog_clear_instr,
	input wire logic wdt_tick,
	output logic timer_irq,
	output logic wdt_timeout
);
	import tcp_pkg::*;

	tcp_phase_e phase_ff;
	logic [DATA_W-1:0] option_ff;
	logic [DATA_W-1:0] count_ff;
	logic overflow_irq_enable_ff;
	logic overflow_flag_ff;
	logic [INH_W-1:0] inh_cnt_ff;
	logic path_prev_ff;
	logic ext_delay_ff;
	logic wdt_prev_ff;
	logic [DATA_W-1:0] rdata_ff;
	logic irq_ff;
	logic wdt_timeout_ff;

	logic wr_count;
	logic wr_option;
	logic wr_irq_ctrl;
	logic clock_source_select;
	logic count_edge_select;
	logic prescaler_assignment;
	logic [RATIO_W-1:0] prescale_ratio_field;
	logic sample_en;
	logic instr_level;
	logic src_level;
	logic path_level;
	logic tmr_rise;
	logic sync_rise;
	logic cnt_ev;
	logic inc_go;
	logic wrap;

	tcp_presc_if pif ();

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] t);
		return a == t;
	endfunction

	function automatic logic [DATA_W-1:0] rd_mux(input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] cnt, input logic [DATA_W-1:0] opt,
		input logic en, input logic flg);
		logic [DATA_W-1:0] v;
		v = '0;
		if (addr_hit(a, ADDR_COUNT)) begin
			v = cnt;
		end else if (addr_hit(a, ADDR_OPTION)) begin
			v = opt;
		end else if (addr_hit(a, ADDR_IRQ_CTRL)) begin
			v[IRQ_EN_BIT] = en;
			v[IRQ_FLAG_BIT] = flg;
		end
		return v;
	endfunction

	// =====================================================================
	// register decode
	assign wr_count = reg_wr && addr_hit(reg_addr, ADDR_COUNT);
	assign wr_option = reg_wr && addr_hit(reg_addr, ADDR_OPTION);
	assign wr_irq_ctrl = reg_wr && addr_hit(reg_addr, ADDR_IRQ_CTRL);
	assign clock_source_select = option_ff[OPT_CS_BIT];
	assign count_edge_select = option_ff[OPT_EDGE_BIT];
	assign prescaler_assignment = option_ff[OPT_PSA_BIT];
	assign prescale_ratio_field = option_ff[OPT_RATIO_LSB +: RATIO_W];

	// =====================================================================
	// instruction phases
	always_ff @(posedge mclk) begin
		if (rst) begin
			phase_ff <= TCP_Q1;
		end else begin
			unique case (phase_ff)
				TCP_Q1: phase_ff <= TCP_Q2;
				TCP_Q2: phase_ff <= TCP_Q3;
				TCP_Q3: phase_ff <= TCP_Q4;
				TCP_Q4: phase_ff <= TCP_Q1;
			endcase
		end
	end

	assign sample_en = (phase_ff == TCP_Q2) || (phase_ff == TCP_Q4);
	assign instr_level = (phase_ff == TCP_Q3) || (phase_ff == TCP_Q4);

	// =====================================================================
	// clock source and prescaler routing
	// falling edge select just inverts the pin so one rising detector serves both
	assign src_level = clock_source_select ? (count_input_pin ^ count_edge_select) : instr_level;

	assign pif.in_level = prescaler_assignment ? wdt_tick : src_level;
	assign pif.run = !sleep;
	assign pif.ratio = prescale_ratio_field;
	assign pif.clr = (wr_count && !prescaler_assignment)
		|| (watchdog_clear_instr && prescaler_assignment);

	assign path_level = prescaler_assignment ? src_level : pif.out_tmr;

	tcp_prescaler #(
		.W(PSC_W)
	) u_presc (
		.mclk(mclk),
		.rst(rst),
		.pif(pif.psc)
	);

	// =====================================================================
	// edge paths
	always_ff @(posedge mclk) begin
		if (rst) begin
			path_prev_ff <= 1'h0;
		end else begin
			path_prev_ff <= path_level;
		end
	end

	assign tmr_rise = path_level && !path_prev_ff;

	tcp_q_sampler u_samp (
		.mclk(mclk),
		.rst(rst),
		.level(path_level),
		.sample_en(sample_en),
		.rise(sync_rise)
	);

	// one more stage after synchronising, as the real counter lags its edge
	always_ff @(posedge mclk) begin
		if (rst) begin
			ext_delay_ff <= 1'h0;
		end else begin
			ext_delay_ff <= sync_rise;
		end
	end

	assign cnt_ev = clock_source_select ? ext_delay_ff : tmr_rise;

	// =====================================================================
	// write inhibit
	always_ff @(posedge mclk) begin
		if (rst) begin
			inh_cnt_ff <= '0;
		end else if (wr_count) begin
			inh_cnt_ff <= INH_W'(INHIBIT_CYC);
		end else if (inh_cnt_ff != '0) begin
			inh_cnt_ff <= inh_cnt_ff - 1'h1;
		end
	end

	assign inc_go = cnt_ev && (inh_cnt_ff == '0) && !sleep;
	assign wrap = inc_go && !wr_count && (count_ff == COUNT_MAX);

	// =====================================================================
	// count register
	// a write in the same cycle as an increment wins: software sees its value
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_ff <= COUNT_RST;
		end else if (wr_count) begin
			count_ff <= reg_wdata;
		end else if (inc_go) begin
			count_ff <= count_ff + 1'h1;
		end
	end

	// =====================================================================
	// control registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			option_ff <= OPTION_RST;
		end else if (wr_option) begin
			option_ff <= reg_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			overflow_irq_enable_ff <= 1'h0;
		end else if (wr_irq_ctrl) begin
			overflow_irq_enable_ff <= reg_wdata[IRQ_EN_BIT];
		end
	end

	// set beats a software clear in the same cycle; only software clears it
	always_ff @(posedge mclk) begin
		if (rst) begin
			overflow_flag_ff <= 1'h0;
		end else if (wrap) begin
			overflow_flag_ff <= 1'h1;
		end else if (wr_irq_ctrl) begin
			overflow_flag_ff <= reg_wdata[IRQ_FLAG_BIT];
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			irq_ff <= 1'h0;
		end else begin
			irq_ff <= overflow_flag_ff && overflow_irq_enable_ff;
		end
	end

	// =====================================================================
	// watchdog side of the prescaler
	always_ff @(posedge mclk) begin
		if (rst) begin
			wdt_prev_ff <= 1'h0;
			wdt_timeout_ff <= 1'h0;
		end else begin
			wdt_prev_ff <= pif.out_wdt;
			wdt_timeout_ff <= prescaler_assignment && pif.out_wdt && !wdt_prev_ff;
		end
	end

	// =====================================================================
	// read port
	always_ff @(posedge mclk) begin
		if (rst) begin
			rdata_ff <= '0;
		end else if (reg_rd) begin
			rdata_ff <= rd_mux(reg_addr, count_ff, option_ff, overflow_irq_enable_ff,
				overflow_flag_ff);
		end else begin
			rdata_ff <= '0;
		end
	end

	assign reg_rdata = rdata_ff;
	assign timer_irq = irq_ff;
	assign wdt_timeout = wdt_timeout_ff;

	// =====================================================================
	// checks
	logic [INH_W-1:0] gap_ff;
	logic tmr_steady;

	assign tmr_steady = !clock_source_select && prescaler_assignment && !sleep
		&& (inh_cnt_ff == '0) && !reg_wr
		&& (path_prev_ff == ((phase_ff == TCP_Q4) || (phase_ff == TCP_Q1))); // edge history settled

	always_ff @(posedge mclk) begin
		if (rst || !tmr_steady || inc_go) begin
			gap_ff <= '0;
		end else if (gap_ff != '1) begin
			gap_ff <= gap_ff + 1'h1;
		end
	end

	property p_timer_rate;
		@(posedge mclk) disable iff (rst) gap_ff < INH_W'(Q_PER_INSTR);
	endproperty
	a_timer_rate: assert property (p_timer_rate) else $error("timer missed a cycle");

	property p_write_inhibit;
		@(posedge mclk) disable iff (rst) wr_count |=> (!inc_go) [*8];
	endproperty
	a_write_inhibit: assert property (p_write_inhibit) else $error("count during inhibit");

	property p_wrap_flag;
		@(posedge mclk) disable iff (rst) wrap |=> (overflow_flag_ff && count_ff == '0);
	endproperty
	a_wrap_flag: assert property (p_wrap_flag) else $error("wrap did not set flag");

	property p_irq_mask;
		@(posedge mclk) disable iff (rst) !overflow_irq_enable_ff |=> !timer_irq;
	endproperty
	a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised");

	property p_irq_on;
		@(posedge mclk) disable iff (rst)
		(overflow_flag_ff && overflow_irq_enable_ff) |=> timer_irq;
	endproperty
	a_irq_on: assert property (p_irq_on) else $error("enabled irq missing");

	property p_sleep_hold;
		@(posedge mclk) disable iff (rst)
		(sleep && !wr_count) |=> (count_ff == $past(count_ff));
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("counted in sleep");

	property p_ext_delay;
		@(posedge mclk) disable iff (rst)
		(clock_source_select && sync_rise && !wr_option) |=>
			(inc_go || sleep || inh_cnt_ff != '0);
	endproperty
	a_ext_delay: assert property (p_ext_delay) else $error("synced edge lost");

	property p_clr_by_write;
		@(posedge mclk) disable iff (rst) (wr_count && !prescaler_assignment) |=> (pif.cnt == '0);
	endproperty
	a_clr_by_write: assert property (p_clr_by_write) else $error("write left prescaler");

	property p_clr_by_wdt;
		@(posedge mclk) disable iff (rst)
		(watchdog_clear_instr && prescaler_assignment) |=> (pif.cnt == '0);
	endproperty
	a_clr_by_wdt: assert property (p_clr_by_wdt) else $error("watchdog clear missed");

	property p_no_wdt_post;
		@(posedge mclk) disable iff (rst) !prescaler_assignment |=> !wdt_timeout;
	endproperty
	a_no_wdt_post: assert property (p_no_wdt_post) else $error("watchdog tick while owned");

endmodule
